// ==== logic/dis_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing figures of the init sequencer.
// Assumes: Byte addresses on a 32-bit bus, one aligned word per register.
// Notes:   Included by its bare name from the sequencer module only.
`ifndef DIS_DEFINES_SVH
`define DIS_DEFINES_SVH

// Clock rate of clk_i in MHz.
`define DIS_CLK_MHZ       125
// Waits in microseconds.
`define DIS_T_PWR_US      200
`define DIS_T_PLL_US      100
`define DIS_T_DLL_US      100
// Refresh interval in nanoseconds per grade.
`define DIS_TREF_COM_NS   32'h0000_1e78
`define DIS_TREF_IND_NS   32'h0000_0f3c

// Own register map.
`define DIS_OFS_CTRL      8'h00
`define DIS_OFS_STATUS    8'h04
`define DIS_OFS_REFRESH   8'h08
`define DIS_OFS_SHADOW    8'h40
`define DIS_OFS_SHADOW_LO 8'h88
`define DIS_CTRL_RST      32'h0000_0000
`define DIS_SHADOW_RST    32'h0000_0000
// Control fields.
`define DIS_CTRL_START    0
`define DIS_CTRL_DDR3     1
`define DIS_CTRL_IND      2
// Status fields.
`define DIS_ST_BUSY       0
`define DIS_ST_DONE       1

// Device register map.
`define DIS_DEV_CFG       8'h00
`define DIS_DEV_STATE     8'h04
`define DIS_DEV_MODE      8'h08
`define DIS_DEV_EMR23     8'h0c
`define DIS_DEV_RANK      8'h10
`define DIS_DEV_TP0       8'h14
`define DIS_DEV_TP1       8'h18
`define DIS_DEV_TP2       8'h1c
`define DIS_DEV_PHY_CMD   8'h20
`define DIS_DEV_PHY_DLL   8'h24
`define DIS_DEV_PHY_COMP  8'h28
`define DIS_DEV_ARB       8'h30
`define DIS_DEV_GNT_A     8'h34
`define DIS_DEV_GNT_B     8'h38
`define DIS_DEV_PHY_WRRD  8'h3c
`define DIS_DEV_WLVL_A    8'h60
`define DIS_DEV_WLVL_B    8'h64
`define DIS_DEV_WLVL_C    8'h68
`define DIS_DEV_RLVL_A    8'h70
`define DIS_DEV_RGATE     8'h74
// State control fields and values.
`define DIS_DEV_INIT_CMD  32'h0000_0001
`define DIS_DEV_INIT_OK   8
// Shadow table size and list ends.
`define DIS_NUM_SHADOW    19
`define DIS_LAST_DDR2     5'd14
`define DIS_LAST_DDR3     5'd18
`define DIS_DDR2_RGATE    5'd14
`define DIS_IDX_RGATE     5'd18

`endif

// ==== logic/dis_pkg.sv ====
// Purpose: Types shared by the init sequencer modules.
// Assumes: Constants come from dis_defines.svh.
// Notes:   Nothing here is imported; users write dis_pkg::name.
package dis_pkg;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_PWR_WAIT = 4'h1,
		ST_PD_REL   = 4'h2,
		ST_REG_REQ  = 4'h3,
		ST_REG_ACK  = 4'h4,
		ST_PLL_WAIT = 4'h5,
		ST_DLL_PD   = 4'h6,
		ST_DLL_WAIT = 4'h7,
		ST_RST_REL  = 4'h8,
		ST_INIT_REQ = 4'h9,
		ST_INIT_ACK = 4'ha,
		ST_POLL_REQ = 4'hb,
		ST_POLL_ACK = 4'hc,
		ST_DONE     = 4'hd
	} dis_state_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} dis_dev_req_t;

endpackage : dis_pkg

// ==== logic/dis_wait_timer.sv ====
// Purpose: Down counter that flags the end of a timed wait.
// Assumes: Load count is at least one cycle.
// Notes:   done_o stays high until the next load.
`timescale 1ns/1ps
module dis_wait_timer (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// Control
	input  wire logic        load_i,
	input  wire logic [31:0] count_i,
	// Status
	output logic             done_o
);

	logic [31:0] cnt_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_r  <= 32'h0000_0000;
			done_o <= 1'b0;
		end else if (load_i) begin
			cnt_r  <= count_i;
			done_o <= 1'b0;
		end else if (cnt_r != 32'h0000_0000) begin
			cnt_r  <= cnt_r - 32'h0000_0001;
			done_o <= (cnt_r == 32'h0000_0001);
		end
	end

endmodule : dis_wait_timer

// ==== logic/dis_init_seq.sv ====
// Purpose: Host-side power-up sequencer for a DDR2/DDR3 controller and its PHY.
// Assumes: The controller register port runs on clk_i; software uses classic Wishbone.
// Notes:   Software fills the shadow table, picks the mode, then sets start.
//
// Behaviour
// - Wait 200us after power before anything.
// - DDR2: release DLL power-down before configuration.
// - DDR2: write 0x00..0x3C and 0x74 first.
// - DDR2: release PHY reset, then init command.
// - Writing bit 0 at 0x04 starts initialization.
// - Bit 8 at 0x04 flags init complete.
// - DDR3: release PLL power-down before configuration.
// - DDR3: write timing registers 0x14, 0x18, 0x1C.
// - DDR3: write leveling registers 0x60..0x74.
// - DDR3: PLL reset 100us after PLL power.
// - DDR3: DLL power, wait 100us, DLL reset.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dis_defines.svh"
module dis_init_seq #(
	parameter int unsigned PWR_CYC = `DIS_T_PWR_US * `DIS_CLK_MHZ,
	parameter int unsigned PLL_CYC = `DIS_T_PLL_US * `DIS_CLK_MHZ,
	parameter int unsigned DLL_CYC = `DIS_T_DLL_US * `DIS_CLK_MHZ
) (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	// Software Wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic [31:0]              wb_dat_o,
	output logic                     wb_ack_o,
	// Controller register port
	output dis_pkg::dis_dev_req_t    dev_req_o,
	input  wire logic                dev_ack_i,
	input  wire logic [31:0]         dev_dat_i,
	// PHY controls
	output logic                     phy_dll_power_gate_n_o,
	output logic                     phy_rst_release_n_o,
	output logic                     phy_pll_power_gate_n_o,
	output logic                     phy_pll_rst_n_o,
	output logic                     phy_dll_power_gate_ddr3_n_o,
	output logic                     phy_dll_rst_n_o,
	// Memory traffic permission
	output logic                     init_done_o
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	function automatic logic [7:0] dev_off(input logic [4:0] idx);
		case (idx)
			5'd0:    dev_off = `DIS_DEV_CFG;
			5'd1:    dev_off = `DIS_DEV_MODE;
			5'd2:    dev_off = `DIS_DEV_EMR23;
			5'd3:    dev_off = `DIS_DEV_RANK;
			5'd4:    dev_off = `DIS_DEV_TP0;
			5'd5:    dev_off = `DIS_DEV_TP1;
			5'd6:    dev_off = `DIS_DEV_TP2;
			5'd7:    dev_off = `DIS_DEV_PHY_CMD;
			5'd8:    dev_off = `DIS_DEV_PHY_DLL;
			5'd9:    dev_off = `DIS_DEV_PHY_COMP;
			5'd10:   dev_off = `DIS_DEV_ARB;
			5'd11:   dev_off = `DIS_DEV_GNT_A;
			5'd12:   dev_off = `DIS_DEV_GNT_B;
			5'd13:   dev_off = `DIS_DEV_PHY_WRRD;
			5'd14:   dev_off = `DIS_DEV_WLVL_A;
			5'd15:   dev_off = `DIS_DEV_WLVL_B;
			5'd16:   dev_off = `DIS_DEV_WLVL_C;
			5'd17:   dev_off = `DIS_DEV_RLVL_A;
			5'd18:   dev_off = `DIS_DEV_RGATE;
			default: dev_off = `DIS_DEV_CFG;
		endcase
	endfunction : dev_off

	// Maps a list position to a shadow index; DDR2 skips leveling.
	function automatic logic [4:0] list_idx(input logic [4:0] pos, input logic ddr3);
		if (!ddr3 && pos == `DIS_DDR2_RGATE)
			list_idx = `DIS_IDX_RGATE;
		else
			list_idx = pos;
	endfunction : list_idx

	////////////////////////////////////////////////////////////////////////////
	// Software registers.

	dis_pkg::dis_state_t state_r;
	dis_pkg::dis_state_t state_nxt;
	logic [31:0]         ctrl_r;
	logic [31:0]         shadow_r [`DIS_NUM_SHADOW];
	logic [4:0]          pos_r;
	logic                done_r;
	logic                tmr_done_w;

	wire        wb_req_w   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wb_wr_w    = wb_req_w & wb_we_i;
	wire        hit_ctrl_w = (wb_adr_i == `DIS_OFS_CTRL);
	wire        hit_stat_w = (wb_adr_i == `DIS_OFS_STATUS);
	wire        hit_ref_w  = (wb_adr_i == `DIS_OFS_REFRESH);
	wire        hit_sh_w   = (wb_adr_i >= `DIS_OFS_SHADOW) && (wb_adr_i <= `DIS_OFS_SHADOW_LO)
	                         && (wb_adr_i[1:0] == 2'h0);
	wire [7:0]  sh_diff_w  = wb_adr_i - `DIS_OFS_SHADOW;
	wire [4:0]  sh_idx_w   = sh_diff_w[6:2];
	wire        busy_w     = (state_r != dis_pkg::ST_IDLE) && (state_r != dis_pkg::ST_DONE);
	wire        start_w    = wb_wr_w & hit_ctrl_w & wb_sel_i[0] & wb_dat_i[`DIS_CTRL_START]
	                         & ~busy_w;
	wire        ddr3_w     = ctrl_r[`DIS_CTRL_DDR3];
	wire [31:0] refresh_w  = ctrl_r[`DIS_CTRL_IND] ? `DIS_TREF_IND_NS : `DIS_TREF_COM_NS;
	wire [31:0] status_w   = {11'h000, pos_r, 4'h0, state_r, 4'h0, ctrl_r[`DIS_CTRL_IND],
	                          ddr3_w, done_r, busy_w};
	wire [31:0] rd_w       = hit_ctrl_w ? ctrl_r :
	                         hit_stat_w ? status_w :
	                         hit_ref_w  ? refresh_w :
	                         hit_sh_w   ? shadow_r[sh_idx_w] : 32'h0000_0000;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req_w;
			wb_dat_o <= wb_req_w ? rd_w : 32'h0000_0000;
		end
	end

	// Mode bits are frozen while a sequence runs; start is not stored.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ctrl_r <= `DIS_CTRL_RST;
		else if (wb_wr_w && hit_ctrl_w && wb_sel_i[0] && !busy_w)
			ctrl_r <= {29'h0000_0000, wb_dat_i[`DIS_CTRL_IND:`DIS_CTRL_DDR3], 1'b0};
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < `DIS_NUM_SHADOW; i++)
				shadow_r[i] <= `DIS_SHADOW_RST;
		end else if (wb_wr_w && hit_sh_w) begin
			for (int b = 0; b < 4; b++)
				if (wb_sel_i[b])
					shadow_r[sh_idx_w][b*8 +: 8] <= wb_dat_i[b*8 +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer.

	wire [4:0]  last_w    = ddr3_w ? `DIS_LAST_DDR3 : `DIS_LAST_DDR2;
	wire [4:0]  cur_idx_w = list_idx(pos_r, ddr3_w);
	wire        ack_w     = dev_ack_i & dev_req_o.cyc;
	wire        tmr_load_w = start_w | (state_r == dis_pkg::ST_PD_REL && ddr3_w)
	                         | (state_r == dis_pkg::ST_DLL_PD);
	wire [31:0] tmr_cnt_w  = start_w ? PWR_CYC :
	                         (state_r == dis_pkg::ST_PD_REL) ? PLL_CYC : DLL_CYC;

	dis_wait_timer u_timer (
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.load_i    (tmr_load_w),
		.count_i   (tmr_cnt_w),
		.done_o    (tmr_done_w)
	);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			dis_pkg::ST_IDLE, dis_pkg::ST_DONE: begin
				if (start_w)
					state_nxt = dis_pkg::ST_PWR_WAIT;
			end
			dis_pkg::ST_PWR_WAIT: begin
				if (tmr_done_w)
					state_nxt = dis_pkg::ST_PD_REL;
			end
			dis_pkg::ST_PD_REL:   state_nxt = dis_pkg::ST_REG_REQ;
			dis_pkg::ST_REG_REQ:  state_nxt = dis_pkg::ST_REG_ACK;
			dis_pkg::ST_REG_ACK: begin
				if (ack_w && pos_r == last_w)
					state_nxt = ddr3_w ? dis_pkg::ST_PLL_WAIT : dis_pkg::ST_RST_REL;
				else if (ack_w)
					state_nxt = dis_pkg::ST_REG_REQ;
			end
			dis_pkg::ST_PLL_WAIT: begin
				if (tmr_done_w)
					state_nxt = dis_pkg::ST_DLL_PD;
			end
			dis_pkg::ST_DLL_PD:   state_nxt = dis_pkg::ST_DLL_WAIT;
			dis_pkg::ST_DLL_WAIT: begin
				if (tmr_done_w)
					state_nxt = dis_pkg::ST_RST_REL;
			end
			dis_pkg::ST_RST_REL:  state_nxt = dis_pkg::ST_INIT_REQ;
			dis_pkg::ST_INIT_REQ: state_nxt = dis_pkg::ST_INIT_ACK;
			dis_pkg::ST_INIT_ACK: begin
				if (ack_w)
					state_nxt = dis_pkg::ST_POLL_REQ;
			end
			dis_pkg::ST_POLL_REQ: state_nxt = dis_pkg::ST_POLL_ACK;
			dis_pkg::ST_POLL_ACK: begin
				if (ack_w)
					state_nxt = dev_dat_i[`DIS_DEV_INIT_OK] ? dis_pkg::ST_DONE
					                                       : dis_pkg::ST_POLL_REQ;
			end
			default:              state_nxt = dis_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_r <= dis_pkg::ST_IDLE;
			pos_r   <= 5'd0;
		end else begin
			state_r <= state_nxt;
			if (state_r == dis_pkg::ST_PD_REL)
				pos_r <= 5'd0;
			else if (state_r == dis_pkg::ST_REG_ACK && ack_w && pos_r != last_w)
				pos_r <= pos_r + 5'd1;
		end
	end

	// Device request: raised from a REQ state, held until ack, then dropped.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dev_req_o <= '0;
		end else if (state_r == dis_pkg::ST_REG_REQ) begin
			dev_req_o <= {1'b1, 1'b1, 1'b1, dev_off(cur_idx_w), 4'hf, shadow_r[cur_idx_w]};
		end else if (state_r == dis_pkg::ST_INIT_REQ) begin
			dev_req_o <= {1'b1, 1'b1, 1'b1, `DIS_DEV_STATE, 4'hf, `DIS_DEV_INIT_CMD};
		end else if (state_r == dis_pkg::ST_POLL_REQ) begin
			dev_req_o <= {1'b1, 1'b1, 1'b0, `DIS_DEV_STATE, 4'hf, 32'h0000_0000};
		end else if (ack_w) begin
			dev_req_o.cyc <= 1'b0;
			dev_req_o.stb <= 1'b0;
		end
	end

	// PHY controls: all held low from start, those of the selected mode released step by step.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phy_dll_power_gate_n_o      <= 1'b0;
			phy_rst_release_n_o         <= 1'b0;
			phy_pll_power_gate_n_o      <= 1'b0;
			phy_pll_rst_n_o             <= 1'b0;
			phy_dll_power_gate_ddr3_n_o <= 1'b0;
			phy_dll_rst_n_o             <= 1'b0;
			init_done_o                 <= 1'b0;
			done_r                      <= 1'b0;
		end else if (start_w) begin
			phy_dll_power_gate_n_o      <= 1'b0;
			phy_rst_release_n_o         <= 1'b0;
			phy_pll_power_gate_n_o      <= 1'b0;
			phy_pll_rst_n_o             <= 1'b0;
			phy_dll_power_gate_ddr3_n_o <= 1'b0;
			phy_dll_rst_n_o             <= 1'b0;
			init_done_o                 <= 1'b0;
			done_r                      <= 1'b0;
		end else begin
			if (state_r == dis_pkg::ST_PD_REL && !ddr3_w)
				phy_dll_power_gate_n_o <= 1'b1;
			if (state_r == dis_pkg::ST_PD_REL && ddr3_w)
				phy_pll_power_gate_n_o <= 1'b1;
			if (state_r == dis_pkg::ST_PLL_WAIT && tmr_done_w)
				phy_pll_rst_n_o <= 1'b1;
			if (state_r == dis_pkg::ST_DLL_PD)
				phy_dll_power_gate_ddr3_n_o <= 1'b1;
			if (state_r == dis_pkg::ST_RST_REL && !ddr3_w)
				phy_rst_release_n_o <= 1'b1;
			if (state_r == dis_pkg::ST_RST_REL && ddr3_w)
				phy_dll_rst_n_o <= 1'b1;
			if (state_nxt == dis_pkg::ST_DONE && state_r == dis_pkg::ST_POLL_ACK) begin
				init_done_o <= 1'b1;
				done_r      <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	logic [31:0] since_start_r;
	logic [31:0] since_pll_r;
	logic [31:0] since_dll_r;
	logic [4:0]  wr_cnt_r;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			since_start_r <= 32'h0000_0000;
			since_pll_r   <= 32'h0000_0000;
			since_dll_r   <= 32'h0000_0000;
			wr_cnt_r      <= 5'd0;
		end else begin
			since_start_r <= start_w ? 32'h0000_0000 : since_start_r + 32'h0000_0001;
			since_pll_r   <= !phy_pll_power_gate_n_o ? 32'h0000_0000 : since_pll_r + 32'h0000_0001;
			since_dll_r   <= !phy_dll_power_gate_ddr3_n_o ? 32'h0000_0000
			                 : since_dll_r + 32'h0000_0001;
			if (start_w)
				wr_cnt_r <= 5'd0;
			else if (ack_w && dev_req_o.we && state_r == dis_pkg::ST_REG_ACK)
				wr_cnt_r <= wr_cnt_r + 5'd1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	sequence s_poll_ok;
		state_r == dis_pkg::ST_POLL_ACK && ack_w && dev_dat_i[`DIS_DEV_INIT_OK];
	endsequence
	sequence s_init_write;
		dev_req_o.cyc && dev_req_o.we && dev_req_o.adr == `DIS_DEV_STATE;
	endsequence

	chk_power_wait: assert property (
		$rose(phy_dll_power_gate_n_o) || $rose(phy_pll_power_gate_n_o)
		|-> since_start_r >= PWR_CYC)
		else $error("PHY released before the power wait ended.");
	chk_ddr2_dll_first: assert property (
		dev_req_o.cyc && !ddr3_w |-> phy_dll_power_gate_n_o)
		else $error("DDR2 register access before DLL power release.");
	chk_ddr2_regs_done: assert property (
		$rose(phy_rst_release_n_o) |-> wr_cnt_r == 5'd15)
		else $error("PHY reset released before all DDR2 registers were written.");
	chk_init_after_rst: assert property (
		s_init_write |-> (ddr3_w ? phy_dll_rst_n_o : phy_rst_release_n_o))
		else $error("Init command issued before the PHY reset release.");
	chk_init_cmd_value: assert property (
		s_init_write |-> dev_req_o.dat == `DIS_DEV_INIT_CMD && dev_req_o.sel == 4'hf)
		else $error("Init command carries a wrong value.");
	chk_done_follows: assert property (
		s_poll_ok |=> init_done_o ##1 init_done_o)
		else $error("Done not raised after the complete flag was read.");
	chk_ddr3_pll_first: assert property (
		dev_req_o.cyc && ddr3_w |-> phy_pll_power_gate_n_o)
		else $error("DDR3 register access before PLL power release.");
	chk_ddr3_regs_done: assert property (
		$rose(phy_pll_rst_n_o) |-> wr_cnt_r == 5'd19)
		else $error("DDR3 setup incomplete at PLL reset release.");
	chk_pll_rst_wait: assert property (
		$rose(phy_pll_rst_n_o) |-> since_pll_r >= PLL_CYC)
		else $error("PLL reset released too early.");
	chk_dll_rst_wait: assert property (
		$rose(phy_dll_rst_n_o) |-> $past(phy_pll_rst_n_o) && since_dll_r >= DLL_CYC)
		else $error("DLL reset released too early.");
	chk_traffic_gate: assert property (
		$rose(init_done_o) |-> $past(state_r) == dis_pkg::ST_POLL_ACK && $past(ack_w))
		else $error("Memory traffic allowed without a completed poll.");
	chk_req_hold: assert property (
		dev_req_o.cyc && !dev_ack_i |=> dev_req_o.cyc && $stable(dev_req_o))
		else $error("Device request changed before it was acknowledged.");

endmodule : dis_init_seq

// ==== verification/dis_dev_model.sv ====
// Purpose: Behavioural DDR controller register block on the far side of the sequencer.
// Assumes: Classic Wishbone slave on clk_i, ack delayed by lat_i cycles.
// Notes:   Logs every write with the PHY pin levels seen at its ack edge.
`timescale 1ns/1ps
module dis_dev_model #(
	parameter int unsigned INIT_LAT = 12
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	// Register port
	input  wire dis_pkg::dis_dev_req_t req_i,
	output logic                       ack_o,
	output logic [31:0]                dat_o,
	// Test controls
	input  wire logic [3:0]            lat_i,
	input  wire logic [5:0]            pins_i
);
	logic [31:0] regs    [64];
	logic [7:0]  log_adr [32];
	logic [31:0] log_dat [32];
	logic [5:0]  log_pin [32];
	int          n_wr;
	int          init_cnt;
	int          wait_r;
	logic        ok_r;
	logic        ack_r;
	logic [31:0] rd_r;

	////////////////////////////////////////////////////////////////////////////////
	// Released data lines show the inverse of the last value.
	assign ack_o = ack_r;
	assign dat_o = ack_r ? rd_r : ~rd_r;

	////////////////////////////////////////////////////////////////////////////////
	// Register file, init command and completion flag.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ack_r    <= 1'b0;
			wait_r   <= 0;
			n_wr     <= 0;
			ok_r     <= 1'b0;
			init_cnt <= 0;
			rd_r     <= 32'h0000_0000;
			for (int i = 0; i < 64; i++) regs[i] <= 32'h0000_0000;
		end else begin
			ack_r <= 1'b0;
			// Init latency is counted in clk_i cycles.
			if (init_cnt > 1) init_cnt <= init_cnt - 1;
			else if (init_cnt == 1) begin
				init_cnt <= 0;
				ok_r     <= 1'b1;
			end
			if (req_i.cyc && req_i.stb && !ack_r) begin
				if (wait_r >= int'(lat_i)) begin
					ack_r  <= 1'b1;
					wait_r <= 0;
					rd_r   <= (req_i.adr == 8'h04) ? {23'h0, ok_r, 8'h00} : regs[req_i.adr[7:2]];
				end else wait_r <= wait_r + 1;
			end
			if (ack_r && req_i.cyc && req_i.we) begin
				regs[req_i.adr[7:2]] <= req_i.dat;
				log_adr[n_wr[4:0]]   <= req_i.adr;
				log_dat[n_wr[4:0]]   <= req_i.dat;
				log_pin[n_wr[4:0]]   <= pins_i;
				n_wr                 <= n_wr + 1;
				if (req_i.adr == 8'h04 && req_i.dat[0]) begin
					ok_r     <= 1'b0;
					init_cnt <= INIT_LAT;
				end
			end
		end
	end
endmodule : dis_dev_model

// ==== verification/ddr_init_sequencer_test.sv ====
// Purpose: Self-checking bench of the init sequencer with a register block model.
// Assumes: Short wait parameters 20, 10 and 10 cycles.
// Notes:   Table rows first, then DDR2, mid-run reset and DDR3 runs.
`timescale 1ns/1ps
module ddr_init_sequencer_test;
	localparam int unsigned PWR = 20;
	localparam int unsigned PLL = 10;
	localparam int unsigned DLL = 10;
	typedef struct packed {
		logic        we;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
	} dis_row_t;

	logic                  clk_i   = 1'b0;
	logic                  reset_n = 1'b0;
	logic                  cyc     = 1'b0;
	logic                  stb     = 1'b0;
	logic                  we      = 1'b0;
	logic [7:0]            adr     = 8'h00;
	logic [3:0]            sel     = 4'h0;
	logic [31:0]           wdat    = 32'h0000_0000;
	logic [3:0]            lat     = 4'h0;
	logic [5:0]            prev    = 6'h00;
	logic [31:0]           q;
	logic [31:0]           rdat;
	logic                  ack;
	logic                  dack;
	logic [31:0]           ddat;
	logic [5:0]            pins;
	logic                  done;
	logic                  done_d  = 1'b0;
	dis_pkg::dis_dev_req_t dreq;
	int                    n_fail     = 0;
	int                    num_checks = 0;
	int                    cyc_n      = 0;
	int                    t_start    = 0;
	int                    t_rise [6];
	logic [7:0]            ofs [19] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
		8'h20, 8'h24, 8'h28, 8'h30, 8'h34, 8'h38, 8'h3c, 8'h60, 8'h64, 8'h68, 8'h70, 8'h74};
	dis_row_t              rows [8] = '{
		'{1'b1, 8'h40, 32'h1234_5678, 32'h0}, '{1'b0, 8'h40, 32'h0, 32'h1234_5678},
		'{1'b0, 8'h88, 32'h0, 32'h0},         '{1'b0, 8'h08, 32'h0, 32'h0000_1e78},
		'{1'b1, 8'h08, 32'hffff_ffff, 32'h0}, '{1'b0, 8'h08, 32'h0, 32'h0000_1e78},
		'{1'b0, 8'h2c, 32'h0, 32'h0},         '{1'b0, 8'h04, 32'h0, 32'h0}};

	////////////////////////////////////////////////////////////////////////////////
	// Design, model and pin monitor.
	dis_init_seq #(.PWR_CYC(PWR), .PLL_CYC(PLL), .DLL_CYC(DLL)) dut_u (
		.clk_i(clk_i), .reset_n_i(reset_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dev_req_o(dreq), .dev_ack_i(dack), .dev_dat_i(ddat),
		.phy_dll_power_gate_n_o(pins[5]), .phy_rst_release_n_o(pins[4]),
		.phy_pll_power_gate_n_o(pins[3]), .phy_pll_rst_n_o(pins[2]),
		.phy_dll_power_gate_ddr3_n_o(pins[1]), .phy_dll_rst_n_o(pins[0]), .init_done_o(done));
	dis_dev_model dev_u (.clk_i(clk_i), .reset_n_i(reset_n), .req_i(dreq), .ack_o(dack),
		.dat_o(ddat), .lat_i(lat), .pins_i(pins));

	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n <= cyc_n + 1;
		prev  <= pins;
		done_d <= done;
		for (int i = 0; i < 6; i++) if (pins[i] && !prev[i]) t_rise[i] <= cyc_n;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tasks.
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= 4'hf;
		wdat <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 100);
		if (k >= 100) chk(0, 1, "bus timeout");
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task automatic run(input logic [31:0] c, input bit d3);
		int k;
		k = 0;
		wb(1'b1, 8'h00, c, q);
		t_start = cyc_n;
		if (d3) begin
			wb(1'b1, 8'h00, 32'h0, q);
			wb(1'b0, 8'h04, 32'h0, q);
			chk(q[2], 1, "mode changed while busy");
		end
		do begin
			wb(1'b0, 8'h04, 32'h0, q);
			if (q[1] !== 1'b1) chk(done_d, 0, "done early");
			k++;
		end while (q[1] !== 1'b1 && k < 3000);
		@(posedge clk_i);
		chk(done, 1, "init done");
	endtask : run

	task automatic chk_log(input bit d3);
		int n;
		int x;
		n = d3 ? 20 : 16;
		chk(dev_u.n_wr, n, "write count");
		for (int i = 0; i < n - 1; i++) begin
			x = (!d3 && i == 14) ? 18 : i;
			chk(dev_u.log_adr[i], ofs[x], "write order");
			chk(dev_u.log_dat[i], 32'h5a00_0000 + x, "write data");
			chk(dev_u.log_pin[i], d3 ? 6'b001000 : 6'b100000, "pins at config");
		end
		chk(dev_u.log_adr[n - 1], 8'h04, "init cmd address");
		chk(dev_u.log_dat[n - 1], 32'h1, "init cmd data");
		chk(dev_u.log_pin[n - 1], d3 ? 6'b001111 : 6'b110000, "pins at init");
	endtask : chk_log

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog.
	initial begin
		repeat (40000) @(posedge clk_i);
		n_fail++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge clk_i);
		chk({pins, done, ack, dreq.cyc, dreq.stb}, 0, "reset levels");
		reset_n <= 1'b1;
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].a, rows[i].d, q);
			if (!rows[i].we) chk(q, rows[i].e, "register row");
		end
		for (int i = 0; i < 19; i++) wb(1'b1, 8'(8'h40 + 4 * i), 32'h5a00_0000 + i, q);
		run(32'h1, 1'b0);
		chk_log(1'b0);
		chk(32'(t_rise[5] - t_start >= PWR), 1, "power wait");
		wb(1'b1, 8'h00, 32'h1, q);
		repeat (30) @(posedge clk_i);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({pins, done, dreq.cyc}, 0, "mid-run reset");
		reset_n <= 1'b1;
		lat <= 4'h3;
		for (int i = 0; i < 19; i++) wb(1'b1, 8'(8'h40 + 4 * i), 32'h5a00_0000 + i, q);
		run(32'h7, 1'b1);
		chk_log(1'b1);
		chk(32'(t_rise[3] - t_start >= PWR), 1, "power wait");
		chk(32'(t_rise[2] - t_rise[3] >= PLL), 1, "pll wait");
		chk(32'(t_rise[1] > t_rise[2]), 1, "dll power order");
		chk(32'(t_rise[0] - t_rise[1] >= DLL), 1, "dll wait");
		wb(1'b0, 8'h08, 32'h0, q);
		chk(q, 32'h0000_0f3c, "industrial refresh");
		stop_test();
	end
endmodule : ddr_init_sequencer_test
